/* File: lep_pkg.sv */
// Shared constants and types of the LED engine ramp and duty-set executor
package lep_pkg;
    // Clock rates and the engine timing derived from them
    localparam int CLK_HZ = 100_000_000;
    localparam int MASTER_HZ = 32_768;
    localparam int MASTER_DIV = CLK_HZ / MASTER_HZ;
    localparam int PRE0_DIV = 16;
    localparam int PRE1_DIV = 512;
    localparam int SETPWM_TICKS = 16;
    localparam int SETPWM_TIME_US = 488;
    localparam int SETPWM_CYCLES = (SETPWM_TIME_US * (CLK_HZ / 1_000_000));

    // Instruction word fields
    localparam logic [3:0] OP_ARITH = 4'h9;
    localparam logic [1:0] AR_LOAD = 2'h0;
    localparam logic [1:0] AR_ADD = 2'h1;
    localparam logic [1:0] AR_SUB = 2'h2;
    localparam logic [1:0] AR_VAR = 2'h3;
    localparam logic [3:0] VAR_ADD = 4'h0;
    localparam logic [3:0] VAR_SUB = 4'h1;
    localparam logic [7:0] OP_SETPWM_NUM = 8'h40;
    localparam logic [13:0] OP_SETPWM_VAR = 14'h2118;
    localparam logic [5:0] OP_RAMP_VAR = 6'h21;
    localparam int RAMP_PRE_BIT = 14;
    localparam int RAMP_SIGN_BIT = 8;
    localparam int RAMPV_PRE_BIT = 5;
    localparam int RAMPV_SIGN_BIT = 4;

    // Register indices; the byte address is four times the index
    localparam logic [9:0] IDX_LED_CTRL0 = 10'h006;
    localparam logic [9:0] IDX_LED_CTRL2 = 10'h008;
    localparam logic [9:0] IDX_VARIABLE = 10'h03C;
    localparam logic [9:0] IDX_TEST_ADC = 10'h042;
    localparam logic [9:0] IDX_VAR_A = 10'h070;
    localparam logic [9:0] IDX_CONFIG = 10'h071;
    localparam logic [9:0] IDX_STATUS = 10'h072;
    localparam int LOG_EN_BIT = 5;
    localparam int DSRC_BIT = 0;
    localparam logic [7:0] VAR_RST = 8'h00;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Executor states
    typedef enum logic [1:0] {
        LEP_IDLE = 2'b00,
        LEP_RAMP = 2'b01,
        LEP_SETPWM = 2'b10
    } lep_state_t;

    // Ramp parameters latched at instruction start
    typedef struct packed {
        logic prescale;
        logic sign;
        logic [4:0] step_time;
        logic [7:0] step_total;
    } lep_ramp_t;
endpackage : lep_pkg

/* File: lep_exec.sv */
// LED engine executor: variable arithmetic, ramp and direct duty set
// How it works
// RQ1 - Immediate load, add, subtract decode
// RQ2 - Variable add and subtract decode
// RQ3 - Ramp starts at effective duty, unit steps
// RQ4 - Step period from prescale and step time
// RQ5 - Prescale picks master divide by 16 or 512
// RQ6 - Step lasts step time times base cycle
// RQ7 - Sign zero raises, one lowers
// RQ8 - Zero count is a one-step wait
// RQ9 - Saturated ramps still run every step
// RQ10 - Variable ramp operands latched at start
// RQ11 - Step time source A, B, C, D
// RQ12 - Only five low bits give step time
// RQ13 - Step count source A, B, C, D
// RQ14 - Load writes variables, software writes D
// RQ15 - Test result can replace variable D
// RQ16 - Variable A and D readable by software
// RQ17 - Control bit selects log or linear curve
// RQ18 - Duty set loads directly, lasts sixteen ticks
// RQ19 - Duty 0 to 255 spans full range
// RQ20 - Variable duty set picks A, B, C, D
// RQ21 - Zero-step wait flags wait, freezes duty
// RQ22 - Arithmetic wraps modulo 256
// RQ23 - Ramp duty clamps, step counter runs on
module lep_exec #(
    parameter int CHANNELS = 9
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [11:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic instr_done,
    input wire logic [CHANNELS-1:0] led_map,
    input wire logic [7:0] test_adc,
    output logic [CHANNELS-1:0][7:0] led_driver_outputs,
    output logic wait_status,
    output logic busy
);
    lep_pkg::lep_state_t state_reg;
    lep_pkg::lep_ramp_t ramp_reg;
    lep_pkg::lep_ramp_t ramp_next;
    logic [7:0] var_a_reg;
    logic [7:0] var_b_reg;
    logic [7:0] var_c_reg;
    logic [7:0] var_d_reg;
    logic [2:0][7:0] led_ctrl_reg;
    logic dsrc_reg;
    logic [CHANNELS-1:0][7:0] duty_reg;
    logic [7:0] eng_duty_reg;
    logic [7:0] eng_duty_next;
    logic [7:0] start_duty;
    logic [11:0] mdiv_reg;
    logic mtick;
    logic [8:0] base_reg;
    logic btick;
    logic [4:0] step_reg;
    logic step_end;
    logic [7:0] left_reg;
    logic take;
    logic is_arith;
    logic is_setpwm_num;
    logic is_setpwm_var;
    logic is_ramp_num;
    logic is_ramp_var;
    logic var_we;
    logic [1:0] var_tgt;
    logic [7:0] var_val;
    logic duty_we;
    logic [7:0] duty_val;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [9:0] aw_idx_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic [9:0] ar_idx;

    // Variable source mux; selector 3 is D or the self-test result
    function automatic logic [7:0] pick_var(input logic [1:0] sel, input logic [7:0] a,
                                            input logic [7:0] b, input logic [7:0] c,
                                            input logic [7:0] d);
        logic [7:0] v;
        v = d;
        case (sel)
            2'h0: v = a;
            2'h1: v = b;
            2'h2: v = c;
            default: v = d;
        endcase
        return v;
    endfunction : pick_var

    logic [7:0] d_src;
    logic [7:0] time_var;
    assign d_src = dsrc_reg ? test_adc : var_d_reg; // RQ15
    assign time_var = pick_var(instr_word[3:2], var_a_reg, var_b_reg, var_c_reg, d_src);

    // Instruction class decode; duty set sits in the unused step-time-zero slot
    assign take = instr_valid && instr_ready;
    assign instr_ready = (state_reg == lep_pkg::LEP_IDLE);
    assign is_arith = (instr_word[15:12] == lep_pkg::OP_ARITH); // RQ1 RQ2
    assign is_setpwm_num = (instr_word[15:8] == lep_pkg::OP_SETPWM_NUM);
    assign is_setpwm_var = (instr_word[15:2] == lep_pkg::OP_SETPWM_VAR);
    assign is_ramp_num = !instr_word[15] && !is_setpwm_num;
    assign is_ramp_var = (instr_word[15:10] == lep_pkg::OP_RAMP_VAR) && !is_setpwm_var;

    // Arithmetic result, truncated to eight bits so it wraps
    always_comb begin
        logic [7:0] op1;
        logic [7:0] op2;
        op1 = pick_var(instr_word[3:2], var_a_reg, var_b_reg, var_c_reg, d_src);
        op2 = pick_var(instr_word[1:0], var_a_reg, var_b_reg, var_c_reg, d_src);
        var_tgt = instr_word[11:10];
        var_we = 1'b0;
        var_val = instr_word[7:0];
        if (take && is_arith) begin
            var_we = 1'b1;
            case (instr_word[9:8])
                lep_pkg::AR_LOAD: var_val = instr_word[7:0]; // RQ1 RQ14
                lep_pkg::AR_ADD: var_val = 8'(pick_var(var_tgt, var_a_reg, var_b_reg,
                    var_c_reg, var_d_reg) + instr_word[7:0]); // RQ22
                lep_pkg::AR_SUB: var_val = 8'(pick_var(var_tgt, var_a_reg, var_b_reg,
                    var_c_reg, var_d_reg) - instr_word[7:0]); // RQ22
                default: begin
                    if (instr_word[7:4] == lep_pkg::VAR_ADD) begin
                        var_val = 8'(op1 + op2); // RQ2 RQ22
                    end else if (instr_word[7:4] == lep_pkg::VAR_SUB) begin
                        var_val = 8'(op1 - op2); // RQ2 RQ22
                    end else begin
                        var_we = 1'b0;
                    end
                end
            endcase
        end
    end

    // Local and global variables; only the arithmetic group writes A to C
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            var_a_reg <= lep_pkg::VAR_RST;
            var_b_reg <= lep_pkg::VAR_RST;
            var_c_reg <= lep_pkg::VAR_RST;
        end else if (var_we) begin
            if (var_tgt == 2'h0) var_a_reg <= var_val; // RQ14
            if (var_tgt == 2'h1) var_b_reg <= var_val;
            if (var_tgt == 2'h2) var_c_reg <= var_val;
        end
    end

    // Variable D: software write wins over an engine write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            var_d_reg <= lep_pkg::VAR_RST;
        end else if (wr_fire && aw_idx_reg == lep_pkg::IDX_VARIABLE && wstrb_reg[0]) begin
            var_d_reg <= wdata_reg[7:0]; // RQ14
        end else if (var_we && var_tgt == 2'h3) begin
            var_d_reg <= var_val;
        end
    end

    // Ramp operands from the word or, latched once, from variables
    always_comb begin
        ramp_next.prescale = instr_word[lep_pkg::RAMP_PRE_BIT]; // RQ4
        ramp_next.sign = instr_word[lep_pkg::RAMP_SIGN_BIT]; // RQ7
        ramp_next.step_time = instr_word[13:9]; // RQ4
        ramp_next.step_total = instr_word[7:0]; // RQ8
        if (is_setpwm_num || is_setpwm_var) begin
            ramp_next.prescale = 1'b0; // RQ18
            ramp_next.sign = 1'b0;
            ramp_next.step_time = 5'h01;
            ramp_next.step_total = 8'h00;
        end else if (is_ramp_var) begin
            ramp_next.prescale = instr_word[lep_pkg::RAMPV_PRE_BIT];
            ramp_next.sign = instr_word[lep_pkg::RAMPV_SIGN_BIT];
            ramp_next.step_time = time_var[4:0]; // RQ11 RQ12
            ramp_next.step_total = pick_var(instr_word[1:0], var_a_reg, var_b_reg,
                var_c_reg, d_src); // RQ13
        end
    end

    // Effective duty of the lowest mapped output seeds the ramp
    always_comb begin
        start_duty = eng_duty_reg;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (led_map[i]) start_duty = duty_reg[i]; // RQ3
        end
    end

    // Executor state, latched parameters and remaining steps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= lep_pkg::LEP_IDLE;
            ramp_reg <= '0;
            left_reg <= 8'h00;
            instr_done <= 1'b0;
            wait_status <= 1'b0;
        end else begin
            instr_done <= 1'b0;
            case (state_reg)
                lep_pkg::LEP_IDLE: begin
                    if (take) begin
                        ramp_reg <= ramp_next; // RQ10
                        left_reg <= ramp_next.step_total;
                        if (is_ramp_num || is_ramp_var) begin
                            state_reg <= lep_pkg::LEP_RAMP;
                            wait_status <= (ramp_next.step_total == 8'h00); // RQ21
                        end else if (is_setpwm_num || is_setpwm_var) begin
                            state_reg <= lep_pkg::LEP_SETPWM;
                        end else begin
                            instr_done <= 1'b1;
                        end
                    end
                end
                lep_pkg::LEP_RAMP: begin
                    if (step_end) begin
                        left_reg <= 8'(left_reg - 8'h01); // RQ9
                        if (left_reg <= 8'h01) begin
                            state_reg <= lep_pkg::LEP_IDLE; // RQ8 RQ9
                            instr_done <= 1'b1;
                            wait_status <= 1'b0;
                        end
                    end
                end
                default: begin
                    if (step_end) begin
                        state_reg <= lep_pkg::LEP_IDLE; // RQ18
                        instr_done <= 1'b1;
                    end
                end
            endcase
        end
    end
    assign busy = (state_reg != lep_pkg::LEP_IDLE);

    // Master tick from the fast clock; free-running like the real master clock
    always_ff @(posedge aclk) begin
        if (!aresetn || mtick) begin
            mdiv_reg <= 12'h000;
        end else begin
            mdiv_reg <= 12'(mdiv_reg + 12'h001);
        end
    end
    assign mtick = (mdiv_reg == 12'(lep_pkg::MASTER_DIV - 1));

    // Base cycle, restarted per instruction so the first step is short by at most one master tick
    always_ff @(posedge aclk) begin
        if (!aresetn || take || btick) begin
            base_reg <= 9'h000;
        end else if (mtick) begin
            base_reg <= 9'(base_reg + 9'h001);
        end
    end
    assign btick = mtick && (base_reg == (ramp_reg.prescale ? 9'(lep_pkg::PRE1_DIV - 1)
        : 9'(lep_pkg::PRE0_DIV - 1))); // RQ5

    // Step timer: step time base cycles; zero behaves as one
    always_ff @(posedge aclk) begin
        if (!aresetn || take || step_end) begin
            step_reg <= 5'h00;
        end else if (btick) begin
            step_reg <= 5'(step_reg + 5'h01);
        end
    end
    assign step_end = busy && btick && (step_reg + 5'h01 >= ramp_reg.step_time); // RQ6

    // Next engine duty with clamping instead of wrap
    always_comb begin
        eng_duty_next = eng_duty_reg;
        if (ramp_reg.step_total != 8'h00) begin
            if (!ramp_reg.sign && eng_duty_reg != 8'hFF) begin
                eng_duty_next = 8'(eng_duty_reg + 8'h01); // RQ3 RQ7 RQ23
            end else if (ramp_reg.sign && eng_duty_reg != 8'h00) begin
                eng_duty_next = 8'(eng_duty_reg - 8'h01); // RQ3 RQ7 RQ23
            end
        end
    end

    // Duty pushed to mapped outputs at start of a duty set or at each step of a ramp with nonzero count
    always_comb begin
        duty_we = 1'b0;
        duty_val = eng_duty_next;
        if (take && is_setpwm_num) begin
            duty_we = 1'b1;
            duty_val = instr_word[7:0]; // RQ18
        end else if (take && is_setpwm_var) begin
            duty_we = 1'b1;
            duty_val = pick_var(instr_word[1:0], var_a_reg, var_b_reg, var_c_reg,
                d_src); // RQ20
        end else if (state_reg == lep_pkg::LEP_RAMP && step_end
                     && ramp_reg.step_total != 8'h00) begin
            duty_we = 1'b1; // RQ21
        end
    end

    // Engine duty follows the ramp start and every pushed value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eng_duty_reg <= lep_pkg::DUTY_RST;
        end else if (take && (is_ramp_num || is_ramp_var)) begin
            eng_duty_reg <= start_duty; // RQ3
        end else if (duty_we) begin
            eng_duty_reg <= duty_val;
        end
    end

    // Per output: duty store and curve shaping toward the driver
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            logic [15:0] sq;
            logic log_en;
            assign log_en = led_ctrl_reg[ch % 3][lep_pkg::LOG_EN_BIT];
            assign sq = duty_reg[ch] * duty_reg[ch] + 16'h00FF;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    duty_reg[ch] <= lep_pkg::DUTY_RST;
                end else if (duty_we && led_map[ch]) begin
                    duty_reg[ch] <= duty_val;
                end
            end
            // Squared curve stands in for the log table, cheap and monotonic
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    led_driver_outputs[ch] <= 8'h00;
                end else begin
                    led_driver_outputs[ch] <= log_en ? sq[15:8] : duty_reg[ch]; // RQ17 RQ19
                end
            end
        end
    endgenerate

    // Write channel: address and data taken in either order
    assign s_axil_awready = !aw_hold_reg && !s_axil_bvalid;
    assign s_axil_wready = !w_hold_reg && !s_axil_bvalid;
    assign wr_fire = aw_hold_reg && w_hold_reg && !s_axil_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_idx_reg <= 10'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= lep_pkg::RESP_OKAY;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_hold_reg <= 1'b1;
                aw_idx_reg <= s_axil_awaddr[11:2];
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axil_wdata;
                wstrb_reg <= s_axil_wstrb;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axil_bvalid <= 1'b1;
                if ((aw_idx_reg >= lep_pkg::IDX_LED_CTRL0 && aw_idx_reg <= lep_pkg::IDX_LED_CTRL2)
                    || aw_idx_reg == lep_pkg::IDX_VARIABLE
                    || aw_idx_reg == lep_pkg::IDX_CONFIG) begin
                    s_axil_bresp <= lep_pkg::RESP_OKAY;
                end else begin
                    s_axil_bresp <= lep_pkg::RESP_SLVERR;
                end
            end else if (s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
        end
    end

    // Writable control bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_ctrl_reg <= '0;
            dsrc_reg <= 1'b0;
        end else if (wr_fire && wstrb_reg[0]) begin
            if (aw_idx_reg >= lep_pkg::IDX_LED_CTRL0 && aw_idx_reg <= lep_pkg::IDX_LED_CTRL2) begin
                led_ctrl_reg[2'(aw_idx_reg - lep_pkg::IDX_LED_CTRL0)] <= wdata_reg[7:0]; // RQ17
            end else if (aw_idx_reg == lep_pkg::IDX_CONFIG) begin
                dsrc_reg <= wdata_reg[lep_pkg::DSRC_BIT]; // RQ15
            end
        end
    end

    // Read channel: one cycle to data, unmapped reads zero with error
    assign s_axil_arready = !s_axil_rvalid;
    assign ar_idx = s_axil_araddr[11:2];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h0000_0000;
            s_axil_rresp <= lep_pkg::RESP_OKAY;
        end else if (s_axil_arvalid && s_axil_arready) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rresp <= lep_pkg::RESP_OKAY;
            s_axil_rdata <= 32'h0000_0000;
            if (ar_idx >= lep_pkg::IDX_LED_CTRL0 && ar_idx <= lep_pkg::IDX_LED_CTRL2) begin
                s_axil_rdata[7:0] <= led_ctrl_reg[2'(ar_idx - lep_pkg::IDX_LED_CTRL0)];
            end else if (ar_idx == lep_pkg::IDX_VARIABLE) begin
                s_axil_rdata[7:0] <= var_d_reg; // RQ16
            end else if (ar_idx == lep_pkg::IDX_TEST_ADC) begin
                s_axil_rdata[7:0] <= test_adc;
            end else if (ar_idx == lep_pkg::IDX_VAR_A) begin
                s_axil_rdata[7:0] <= var_a_reg; // RQ16
            end else if (ar_idx == lep_pkg::IDX_CONFIG) begin
                s_axil_rdata[lep_pkg::DSRC_BIT] <= dsrc_reg;
            end else if (ar_idx == lep_pkg::IDX_STATUS) begin
                s_axil_rdata[15:0] <= {eng_duty_reg, 5'h00, wait_status, state_reg};
            end else begin
                s_axil_rresp <= lep_pkg::RESP_SLVERR;
            end
        end else if (s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
        end
    end

    // Helper: master ticks seen since the current instruction started
    logic [9:0] mcount_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn || take) begin
            mcount_reg <= 10'h000;
        end else if (mtick) begin
            mcount_reg <= 10'(mcount_reg + 10'h001);
        end
    end

    load_value_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
        take && instr_word[15:8] == 8'h90 |=> var_a_reg == $past(instr_word[7:0]))
        else $error("load did not store the constant");
    add_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ22
        take && instr_word[15:8] == 8'h91 |=> var_a_reg == 8'($past(var_a_reg)
        + $past(instr_word[7:0])))
        else $error("add result not modulo 256");
    ramp_step_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
        state_reg == lep_pkg::LEP_RAMP && step_end && ramp_reg.step_total != 8'h00
        && !ramp_reg.sign && eng_duty_reg != 8'hFF
        |=> eng_duty_reg == 8'($past(eng_duty_reg) + 8'h01))
        else $error("ramp step not plus one");
    clamp_top_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ23
        state_reg == lep_pkg::LEP_RAMP && !ramp_reg.sign && eng_duty_reg == 8'hFF
        |=> eng_duty_reg == 8'hFF)
        else $error("ramp duty wrapped at top");
    wait_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ21
        state_reg == lep_pkg::LEP_RAMP && ramp_reg.step_total == 8'h00
        |-> wait_status ##1 (!busy || $stable(duty_reg)))
        else $error("zero-step wait changed duty");
    setpwm_len_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
        state_reg == lep_pkg::LEP_SETPWM && step_end |-> mcount_reg >= 10'd15
        && mcount_reg <= 10'd16)
        else $error("duty set not sixteen ticks");
    latch_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
        busy && $past(busy) |-> $stable(ramp_reg))
        else $error("ramp operands changed mid-ramp");
    base_div_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
        btick |-> base_reg == (ramp_reg.prescale ? 9'd511 : 9'd15))
        else $error("base cycle divide wrong");
    vard_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
        wr_fire && aw_idx_reg == lep_pkg::IDX_VARIABLE && wstrb_reg[0]
        |=> var_d_reg == $past(wdata_reg[7:0]))
        else $error("software write to D lost");
endmodule : lep_exec

/* File: led_engine_pwm_ops_tb_top.sv */
// Self-checking bench for the LED engine executor
module led_engine_pwm_ops_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MD = lep_pkg::MASTER_DIV;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axil_awaddr = 12'h000, s_axil_araddr = 12'h000;
    logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
    logic [3:0] s_axil_wstrb = 4'hF;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, instr_valid = 1'b0;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic instr_ready, instr_done, wait_status, busy;
    logic [15:0] instr_word = 16'h0000;
    logic [8:0] led_map = 9'h005;
    logic [7:0] test_adc = 8'h00;
    logic [8:0][7:0] led_driver_outputs;
    int seed = 42;
    int num_errors = 0;
    int compares = 0;

    lep_exec i_dut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
        .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
        .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
        .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .instr_word,
        .instr_valid, .instr_ready, .instr_done, .led_map, .test_adc, .led_driver_outputs,
        .wait_status, .busy);

    // Free-running 100 MHz clock
    initial begin
        forever #5 aclk = ~aclk;
    end

    // Counts one comparison, reports a mismatch at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("Checks %0d, errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // Write: both halves offered together, each dropped when taken
    task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
            if (s_axil_bvalid) begin
                r = s_axil_bresp;
                s_axil_bready <= 1'b0;
                break;
            end
        end
    endtask : axw

    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axil_arready) s_axil_arvalid <= 1'b0;
            if (s_axil_rvalid) begin
                d = s_axil_rdata;
                r = s_axil_rresp;
                s_axil_rready <= 1'b0;
                break;
            end
        end
    endtask : axr

    // Issue one instruction while idle, then count cycles until done
    task automatic run(input logic [15:0] w, output int n);
        int bz;
        @(posedge aclk);
        instr_word <= w;
        instr_valid <= 1'b1;
        @(posedge aclk);
        instr_valid <= 1'b0;
        n = 0;
        bz = 0;
        while (instr_done !== 1'b1 && n < 60000) begin
            @(posedge aclk);
            n++;
            if (busy === 1'b1 && instr_ready === 1'b0) bz++;
        end
        chk(bz, n - 1);
    endtask : run

    // Issue one instruction and leave it running for two cycles
    task automatic launch(input logic [15:0] w);
        @(posedge aclk);
        instr_word <= w;
        instr_valid <= 1'b1;
        @(posedge aclk);
        instr_valid <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : launch

    // Main sequence against an integer model of the variables and duty
    initial begin
        logic [1:0] r;
        logic [31:0] d;
        logic [15:0] w;
        logic [7:0] p;
        int n, t, e;
        int v[4];
        v = '{0, 0, 0, 0};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        test_adc <= 8'($random(seed));
        axr(12'h0F0, d, r);
        chk(d, 32'h0);
        p = 8'($random(seed));
        axw(12'h0F0, {24'h0, p}, r);
        v[3] = p;
        axr(12'h0F0, d, r);
        chk(d, p);
        axr(12'h108, d, r);
        chk(d, test_adc);
        axw(12'h108, 32'h5A, r);
        chk(r, lep_pkg::RESP_SLVERR);
        axr(12'h3FC, d, r);
        chk(r, lep_pkg::RESP_SLVERR);
        for (int i = 0; i < 16; i++) begin
            w = 16'($random(seed));
            w[15:12] = 4'h9;
            if (w[9:8] == 2'h3) w[7:5] = 3'h0;
            t = w[11:10];
            case (w[9:8])
                2'h0: v[t] = w[7:0];
                2'h1: v[t] = (v[t] + w[7:0]) % 256;
                2'h2: v[t] = (v[t] - w[7:0] + 256) % 256;
                default: v[t] = (w[4] ? v[w[3:2]] - v[w[1:0]] + 256 : v[w[3:2]] + v[w[1:0]]) % 256;
            endcase
            run(w, n);
            axr(12'h1C0, d, r);
            chk(d, v[0]);
            axr(12'h0F0, d, r);
            chk(d, v[3]);
        end
        axw(12'h1C4, 32'h1, r);
        run(16'h9303, n);
        v[0] = (v[0] + test_adc) % 256;
        axr(12'h1C0, d, r);
        chk(d, v[0]);
        p = 8'($random(seed));
        run({8'h40, p}, n);
        chk(n >= 15 * MD && n <= 16 * MD + 4, 1);
        repeat (2) @(posedge aclk);
        chk(led_driver_outputs[2:0], {p, 8'h00, p});
        run(16'h0301, n);
        chk(n >= 15 * MD && n <= 17 * MD + 4, 1);
        repeat (2) @(posedge aclk);
        e = (p == 0) ? 0 : p - 1;
        chk(led_driver_outputs[2:0], {e[7:0], 8'h00, e[7:0]});
        axw(12'h018, 32'(1 << lep_pkg::LOG_EN_BIT), r);
        @(posedge aclk);
        chk({led_driver_outputs[2], led_driver_outputs[0]}, {e[7:0], 8'((e * e + 255) / 256)});
        launch(16'h8460);
        chk({busy, led_driver_outputs[2]}, {1'b1, 8'(v[0])});
        // Reset in mid-instruction must return everything to idle
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk({busy, instr_ready, wait_status, led_driver_outputs[2]}, {3'b010, 8'h00});
        axr(12'h1C0, d, r);
        chk(d, 32'h0);
        run(16'h9401, n);
        launch(16'h8404);
        chk({wait_status, busy, led_driver_outputs[2]}, {2'b11, 8'h00});
        close_out();
    end

    // Hang guard only slightly past the two long instructions of about 488 us each
    initial begin
        #1_000_000;
        num_errors++;
        close_out();
    end
endmodule : led_engine_pwm_ops_tb_top
